// ### src/carriage_pkg.sv
// Purpose: shared constants and types for the carriage encoder and motor control block
// Assumes: 250 MHz system clock, APB register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package carriage_pkg;

	// ***************************************************
	// clock and timing
	// ***************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SPEED_STEP_NS = 8000; // one speed step, in ns
	localparam int SPEED_STEP_US = 8;
	localparam int SPEED_STEP_CYCLES = (SPEED_STEP_US * 1000000) / CLK_PERIOD_PS;
	localparam logic [7:0] SPEED_COUNT_MAX = 8'hFC; // 252
	localparam int ENC_PPI_NORMAL = 120;
	localparam int ENC_PPI_COMPRESSED = 198;

	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_POSITION = 8'h08;
	localparam logic [7:0] ADDR_SPEED = 8'h0C;
	localparam logic [7:0] ADDR_TARGET = 8'h10;

	// control register fields
	localparam int CTRL_FWD_BIT = 0;
	localparam int CTRL_HIACC_BIT = 1;
	localparam int CTRL_AUTO_BIT = 2;
	localparam int CTRL_MOTOR_BIT = 3;
	localparam int CTRL_COMP_BIT = 4;
	localparam int CTRL_HOME_BIT = 5;
	localparam int CTRL_RESTART_BIT = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [7:0] TARGET_RESET = 8'h40;
	localparam logic [15:0] POS_ZERO = 16'h0000;

	// status register fields
	localparam int STAT_DIR_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_SLOW_BIT = 2;
	localparam int STAT_EVENT_BIT = 3;

	// encoder phase pair
	typedef struct packed {
		logic a;
		logic b;
	} enc_pair_s;

	// decoder states, named by the (a,b) gray position
	typedef enum logic [3:0] {
		ENC_00 = 4'b0001,
		ENC_01 = 4'b0010,
		ENC_11 = 4'b0100,
		ENC_10 = 4'b1000
	} enc_state_e;

endpackage

// ### src/carriage_encoder_motor_ctrl.sv
// Purpose: quadrature decode, position keeping, speed counter and carriage commands
// Assumes: encoder pins asynchronous to pclk; APB master keeps the protocol
// Notes: commands are active low and come straight from flip-flops
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module carriage_encoder_motor_ctrl #(
	parameter int POS_WIDTH = 16,
	parameter int STEP_CYCLES = carriage_pkg::SPEED_STEP_CYCLES,
	parameter int HOME_IDLE_STEPS = 252
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// encoder pins
	input wire carriage_pkg::enc_pair_s enc_normal,
	input wire carriage_pkg::enc_pair_s enc_compressed,
	// motor driver commands
	output logic carriage_dir_cmd_n,
	output logic motor_on_cmd_n,
	output logic accel_level_cmd_n,
	// status pulse and direction level
	output logic sensor_pulse,
	output logic travel_direction_flag
);

	// ***************************************************
	// pitch selection and synchroniser
	// ***************************************************
	logic [31:0] ctrl;
	logic compressed_pitch_select;
	carriage_pkg::enc_pair_s enc_sel;
	carriage_pkg::enc_pair_s sync1;
	carriage_pkg::enc_pair_s sync_sample_clock;

	assign compressed_pitch_select = ctrl[carriage_pkg::CTRL_COMP_BIT];

	// and/or steering ahead of the synchroniser; glitch on switch is absorbed by it
	always_comb begin
		enc_sel.a = (enc_normal.a & ~compressed_pitch_select) | (enc_compressed.a & compressed_pitch_select);
		enc_sel.b = (enc_normal.b & ~compressed_pitch_select) | (enc_compressed.b & compressed_pitch_select);
	end

	// two-stage resample; only stage two is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync_sample_clock <= '0;
		end else begin
			sync1 <= enc_sel;
			sync_sample_clock <= sync1;
		end
	end

	// ***************************************************
	// four-state decoder
	// ***************************************************
	carriage_pkg::enc_state_e enc_state, next_enc_state;
	logic next_sensor_pulse, next_dir;
	carriage_pkg::enc_state_e seen;

	always_comb begin
		case ({sync_sample_clock.a, sync_sample_clock.b})
			2'b00: seen = carriage_pkg::ENC_00;
			2'b01: seen = carriage_pkg::ENC_01;
			2'b11: seen = carriage_pkg::ENC_11;
			default: seen = carriage_pkg::ENC_10;
		endcase
	end

	// forward order 00-01-11-10; a double change is dropped but tracked
	always_comb begin
		next_enc_state = seen;
		next_sensor_pulse = 1'b0;
		next_dir = travel_direction_flag;
		case (enc_state)
			carriage_pkg::ENC_00: begin
				if (seen == carriage_pkg::ENC_01) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b1;
				end else if (seen == carriage_pkg::ENC_10) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b0;
				end
			end
			carriage_pkg::ENC_01: begin
				if (seen == carriage_pkg::ENC_11) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b1;
				end else if (seen == carriage_pkg::ENC_00) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b0;
				end
			end
			carriage_pkg::ENC_11: begin
				if (seen == carriage_pkg::ENC_10) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b1;
				end else if (seen == carriage_pkg::ENC_01) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b0;
				end
			end
			default: begin
				if (seen == carriage_pkg::ENC_00) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b1;
				end else if (seen == carriage_pkg::ENC_11) begin
					next_sensor_pulse = 1'b1;
					next_dir = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_state <= carriage_pkg::ENC_00;
			sensor_pulse <= 1'b0;
			travel_direction_flag <= 1'b1;
		end else begin
			enc_state <= next_enc_state;
			sensor_pulse <= next_sensor_pulse;
			travel_direction_flag <= next_dir;
		end
	end

	// ***************************************************
	// position, speed counter, homing
	// ***************************************************
	logic [POS_WIDTH-1:0] position, next_position;
	logic [7:0] speed_count, next_speed_count, speed_latch, next_speed_latch;
	logic [7:0] target;
	logic speed_count_enable, next_speed_count_enable;
	logic [31:0] step_div, next_step_div;
	logic homing, next_homing;
	logic [7:0] home_idle, next_home_idle;
	logic slow, next_slow;
	logic home_req, restart_req;

	always_comb begin
		next_position = position;
		next_homing = homing;
		next_home_idle = home_idle;
		if (home_req) begin
			next_homing = 1'b1;
			next_home_idle = '0;
		end else if (homing) begin
			// stalled at the stop: no pulse for a full idle window
			if (sensor_pulse) begin
				next_home_idle = '0;
			end else if (speed_count == carriage_pkg::SPEED_COUNT_MAX && home_idle != 8'(HOME_IDLE_STEPS)) begin
				next_home_idle = home_idle + 8'h01;
			end
			if (home_idle == 8'(HOME_IDLE_STEPS)) begin
				next_homing = 1'b0;
				next_position = carriage_pkg::POS_ZERO[POS_WIDTH-1:0];
			end
		end
		if (sensor_pulse && !homing) begin
			next_position = travel_direction_flag ? position + 1'b1 : position - 1'b1;
		end
	end

	// 8 us ticks; stop at 252 or on a pulse, restart on a write of the restart or home bit
	always_comb begin
		next_step_div = step_div;
		next_speed_count = speed_count;
		next_speed_count_enable = speed_count_enable;
		next_speed_latch = speed_latch;
		next_slow = slow;
		if (sensor_pulse) begin
			next_speed_count_enable = 1'b0;
			next_speed_latch = speed_count;
			// longer interval means lower speed
			next_slow = speed_count > target;
		end else if (restart_req || home_req) begin
			// homing opens a fresh idle window, so a stale saturation cannot end it at once
			next_speed_count = '0;
			next_step_div = '0;
			next_speed_count_enable = 1'b1;
		end else if (speed_count_enable) begin
			if (step_div == 32'(STEP_CYCLES - 1)) begin
				next_step_div = '0;
				next_speed_count = speed_count + 8'h01;
				if (speed_count + 8'h01 == carriage_pkg::SPEED_COUNT_MAX) begin
					next_speed_count_enable = 1'b0;
				end
			end else begin
				next_step_div = step_div + 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position <= '0;
			homing <= 1'b0;
			home_idle <= '0;
			step_div <= '0;
			speed_count <= '0;
			speed_count_enable <= 1'b1;
			speed_latch <= '0;
			slow <= 1'b0;
		end else begin
			position <= next_position;
			homing <= next_homing;
			home_idle <= next_home_idle;
			step_div <= next_step_div;
			speed_count <= next_speed_count;
			speed_count_enable <= next_speed_count_enable;
			speed_latch <= next_speed_latch;
			slow <= next_slow;
		end
	end

	// ***************************************************
	// motor commands
	// ***************************************************
	logic next_dir_n, next_motor_n, next_acc_n;

	// homing forces reverse at low acceleration with motor on
	always_comb begin
		if (homing) begin
			next_dir_n = 1'b1;
			next_acc_n = 1'b1;
			next_motor_n = 1'b0;
		end else begin
			next_dir_n = ~ctrl[carriage_pkg::CTRL_FWD_BIT];
			next_acc_n = ~ctrl[carriage_pkg::CTRL_HIACC_BIT];
			if (ctrl[carriage_pkg::CTRL_AUTO_BIT]) begin
				next_motor_n = ~slow;
			end else begin
				next_motor_n = ~ctrl[carriage_pkg::CTRL_MOTOR_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carriage_dir_cmd_n <= 1'b1;
			motor_on_cmd_n <= 1'b1;
			accel_level_cmd_n <= 1'b1;
		end else begin
			carriage_dir_cmd_n <= next_dir_n;
			motor_on_cmd_n <= next_motor_n;
			accel_level_cmd_n <= next_acc_n;
		end
	end

	// ***************************************************
	// apb registers
	// ***************************************************
	logic setup, wr_en;
	logic [31:0] next_ctrl, next_prdata;
	logic [7:0] next_target;
	logic next_pready;

	// zero wait states: pready rises on the setup cycle's following edge
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	// home and restart are write-one pulses, not stored
	assign home_req = wr_en && paddr == carriage_pkg::ADDR_CTRL && pwdata[carriage_pkg::CTRL_HOME_BIT];
	assign restart_req = wr_en && paddr == carriage_pkg::ADDR_CTRL && pwdata[carriage_pkg::CTRL_RESTART_BIT];

	always_comb begin
		next_ctrl = ctrl;
		next_target = target;
		next_pready = setup;
		next_prdata = prdata;
		if (wr_en) begin
			if (paddr == carriage_pkg::ADDR_CTRL) begin
				next_ctrl = pwdata & 32'h0000_001F;
			end else if (paddr == carriage_pkg::ADDR_TARGET) begin
				next_target = pwdata[7:0];
			end
		end
		if (setup && !pwrite) begin
			if (paddr == carriage_pkg::ADDR_CTRL) begin
				next_prdata = ctrl;
			end else if (paddr == carriage_pkg::ADDR_STATUS) begin
				next_prdata = {28'h0, sensor_pulse, slow, homing, travel_direction_flag};
			end else if (paddr == carriage_pkg::ADDR_POSITION) begin
				next_prdata = 32'(position);
			end else if (paddr == carriage_pkg::ADDR_SPEED) begin
				next_prdata = {23'h0, speed_count_enable, speed_latch};
			end else if (paddr == carriage_pkg::ADDR_TARGET) begin
				next_prdata = {24'h0, target};
			end else begin
				next_prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= carriage_pkg::CTRL_RESET;
			target <= carriage_pkg::TARGET_RESET;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			target <= next_target;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= 1'b0;
		end
	end

endmodule

// ### sim/carriage_encoder_motor_ctrl_properties.sv
// Purpose: port checks for the carriage encoder and motor block
// Assumes: encoder pins reach the decoder through two sync flops
// Notes: pitch select is a register bit, so the sync cause check accepts either pair; double-change and direction checks watch the normal pair only
`timescale 1ns/1ps
module carriage_encoder_motor_ctrl_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// encoder and status
	input wire carriage_pkg::enc_pair_s enc_normal,
	input wire carriage_pkg::enc_pair_s enc_compressed,
	input wire logic sensor_pulse,
	input wire logic travel_direction_flag
);
	// ********************************
	// properties
	// ********************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	// pin change three edges back
	sequence s_norm_moved;
		$past(enc_normal, 3) != $past(enc_normal, 4);
	endsequence
	property p_ready;
		s_setup |=> s_access;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_ready_cause;
		pready |-> psel && penable && $past(psel && !penable);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_no_err;
		s_access |-> !pslverr;
	endproperty
	a_no_err: assert property (p_no_err) else $error("slave error raised");
	property p_rd_hold;
		!pready |-> $stable(prdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_sync;
		sensor_pulse |-> s_norm_moved or $past(enc_compressed, 3) != $past(enc_compressed, 4);
	endproperty
	a_sync: assert property (p_sync) else $error("pulse without synced pin change");
	property p_no_double;
		sensor_pulse |-> ($past(enc_normal, 3) ^ $past(enc_normal, 4)) != 2'b11;
	endproperty
	a_no_double: assert property (p_no_double) else $error("pulse on double change");
	property p_dir_value;
		sensor_pulse ##0 s_norm_moved |-> travel_direction_flag == ($past(enc_normal.a, 3) == $past(enc_normal.b, 4));
	endproperty
	a_dir_value: assert property (p_dir_value) else $error("wrong direction level");
	property p_dir_stable;
		$changed(travel_direction_flag) |-> sensor_pulse;
	endproperty
	a_dir_stable: assert property (p_dir_stable) else $error("direction moved alone");
endmodule
bind carriage_encoder_motor_ctrl carriage_encoder_motor_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_normal(enc_normal),
	.enc_compressed(enc_compressed), .sensor_pulse(sensor_pulse), .travel_direction_flag(travel_direction_flag));

// ### sim/carriage_encoder_model.sv
// Purpose: motor encoder on the far side of the carriage block
// Assumes: both tracks start at phase 00
// Notes: k=1 forward, k=3 reverse, k=2 both phases at once
`timescale 1ns/1ps
module carriage_encoder_model (
	// clock
	input wire logic pclk,
	// encoder tracks
	output carriage_pkg::enc_pair_s enc_normal,
	output carriage_pkg::enc_pair_s enc_compressed
);
	int pn = 0;
	int pc = 0;
	// both tracks idle at 00
	initial begin
		enc_normal = 2'b00;
		enc_compressed = 2'b00;
	end
	// gray index keeps the quarter cycle offset between phases
	task step(input bit comp, input int k, input int gap);
		@(posedge pclk);
		if (comp) begin
			pc = (pc + k) % 4;
			enc_compressed <= carriage_pkg::enc_pair_s'(2'(pc ^ (pc >> 1)));
		end else begin
			pn = (pn + k) % 4;
			enc_normal <= carriage_pkg::enc_pair_s'(2'(pn ^ (pn >> 1)));
		end
		repeat (gap) @(posedge pclk);
	endtask
endmodule

// ### sim/carriage_encoder_motor_ctrl_tb.sv
// Purpose: self-checking bench for the carriage block
// Assumes: short speed step and homing counts keep the run brief
// Notes: bench keeps the expected position as an integer
`timescale 1ns/1ps
module carriage_encoder_motor_ctrl_tb;
	// ********************************
	// design and encoder
	// ********************************
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, dir_n, mot_n, acc_n, sensor_pulse, travel_direction_flag;
	carriage_pkg::enc_pair_s enc_normal, enc_compressed;
	int miscompares = 0, checked = 0, cyc = 0, pos = 0;
	always #2 pclk = ~pclk;
	carriage_encoder_motor_ctrl #(.STEP_CYCLES(4), .HOME_IDLE_STEPS(2)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enc_normal(enc_normal), .enc_compressed(enc_compressed),
		.carriage_dir_cmd_n(dir_n), .motor_on_cmd_n(mot_n), .accel_level_cmd_n(acc_n),
		.sensor_pulse(sensor_pulse), .travel_direction_flag(travel_direction_flag));
	carriage_encoder_model enc (.pclk(pclk), .enc_normal(enc_normal), .enc_compressed(enc_compressed));
	task give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// idle cycle first, so a release never meets a new setup
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle budget here: only the hang guard ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, r, e);
	endtask
	// one encoder edge; expected position follows when the pair is selected
	task mv(input bit comp, input int k, input bit seen);
		enc.step(comp, k, 8);
		if (seen && k != 2) begin
			pos += (k == 1) ? 1 : -1;
			chk("direction", travel_direction_flag, k == 1);
		end
	endtask
	// hang guard, well above the planned run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ********************************
	// scenarios
	// ********************************
	initial begin
		void'($urandom(54));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk("idle commands", {dir_n, mot_n, acc_n}, 3'b111);
		rd(carriage_pkg::ADDR_CTRL, 32'h0, "ctrl");
		rd(carriage_pkg::ADDR_TARGET, 32'h40, "target");
		rd(carriage_pkg::ADDR_STATUS, 32'h1, "status");
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h0B);
		repeat (2) @(posedge pclk);
		chk("forward fast", {dir_n, mot_n, acc_n}, 3'b000);
		apb(1'b1, 8'h20, 32'hFF);
		rd(8'h20, 32'h0, "unmapped");
		for (int i = 0; i < 24; i++) mv(0, ($urandom % 2) ? 1 : 3, 1);
		mv(0, 2, 1);
		rd(carriage_pkg::ADDR_POSITION, 32'(pos[15:0]), "position");
		// saturate the speed count, take a slow step, then check it under auto speed
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h40);
		repeat (1100) @(posedge pclk);
		mv(0, 1, 1);
		rd(carriage_pkg::ADDR_SPEED, 32'h0FC, "speed");
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h04);
		repeat (4) @(posedge pclk);
		chk("motor slow", mot_n, 1'b0);
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h44);
		repeat (20) @(posedge pclk);
		mv(0, 3, 1);
		chk("motor fast", mot_n, 1'b1);
		// align tracks before the switch so the mux shows no step
		while (enc.pc != enc.pn) mv(1, 1, 0);
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h10);
		mv(0, 1, 0);
		for (int i = 0; i < 6; i++) mv(1, ($urandom % 2) ? 1 : 3, 1);
		rd(carriage_pkg::ADDR_POSITION, 32'(pos[15:0]), "compressed position");
		apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h20);
		repeat (2) @(posedge pclk);
		chk("homing commands", {dir_n, mot_n, acc_n}, 3'b101);
		repeat (4) begin
			apb(1'b1, carriage_pkg::ADDR_CTRL, 32'h40);
			repeat (1100) @(posedge pclk);
		end
		rd(carriage_pkg::ADDR_POSITION, 32'h0, "home position");
		apb(1'b0, carriage_pkg::ADDR_STATUS, 32'h0);
		chk("homing done", r[1], 1'b0);
		give_verdict();
	end
endmodule
